// ---- rtl/rpd_bank.sv ----
// Reset, power-down control and activation status registers behind an APB slave.
module rpd_bank #(
  parameter int LOSS_CYCLES = rpd_pkg::RPD_LINK_LOSS_CYC
) (
  input wire logic i_core_clk,
  input wire logic i_reset_n,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [11:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  input wire rpd_pkg::rpd_act_ev_t i_ev,
  input wire logic i_dch_enable,
  output logic o_core_reset,
  output logic o_power_down,
  output logic o_abs_power_down,
  output logic o_tx_hiz,
  output logic o_coef_clear,
  output logic o_rtn_pulse,
  output logic o_status_irq
);
  import rpd_pkg::*;

  logic [3:0] ctrl_r;
  logic [3:0] stat_r;
  logic [7:0] diag_r;
  logic irq_r;
  logic dch_r;
  logic pd_r;
  logic abs_q_r;
  logic [31:0] loss_cnt_r;
  logic [31:0] rdata_nxt;
  logic wr_acc;
  logic rd_acc;
  logic soft_rst;
  logic loss_expired;
  logic [3:0] stat_nxt;
  logic [3:0] rise;
  logic [3:0] fall;

  // Every access completes in one access cycle; no wait states.
  assign o_pready = 1'b1;
  assign wr_acc = i_psel && i_penable && i_pwrite;
  assign rd_acc = i_psel && i_penable && !i_pwrite;
  // Absolute power-down acts as a software reset too.
  assign soft_rst = ctrl_r[RPD_SW_RESET_BIT] || ctrl_r[RPD_ABS_PD_BIT]; // [R06] [R11]

  // Only unmapped addresses answer with an error; absolute power-down adds no error of its own.
  always_comb begin
    o_pslverr = 1'b0;
    if (i_psel && i_penable) begin
      if (i_paddr != RPD_CTRL_ADDR && i_paddr != RPD_STAT_ADDR && i_paddr != RPD_DIAG_ADDR
          && i_paddr != RPD_DCH_ADDR && i_paddr != RPD_CORE_ADDR) begin
        o_pslverr = 1'b1;
      end
    end
  end

  // Control register: hardware reset only clears it; software reset leaves it alone.
  always_ff @(posedge i_core_clk) begin
    if (!i_reset_n) begin
      ctrl_r <= RPD_CTRL_RESET; // [R04] [R13]
    end else if (wr_acc && i_paddr == RPD_CTRL_ADDR) begin
      ctrl_r <= i_pwdata[3:0]; // [R01] [R06]
    end
  end

  // Return-to-normal emits a one-cycle clear to the maintenance logic on each write of 1.
  always_ff @(posedge i_core_clk) begin
    if (!i_reset_n) begin
      o_rtn_pulse <= 1'b0;
    end else begin
      o_rtn_pulse <= wr_acc && i_paddr == RPD_CTRL_ADDR && i_pwdata[RPD_RTN_BIT]; // [R14]
    end
  end

  // Diagnostic byte; blocked while in absolute power-down.
  always_ff @(posedge i_core_clk) begin
    if (!i_reset_n || soft_rst) begin
      diag_r <= 8'h00;
    end else if (wr_acc && i_paddr == RPD_DIAG_ADDR) begin
      diag_r <= i_pwdata[7:0]; // [R05]
    end
  end

  // Power-down state: entered only with enable set while waiting for a tone.
  always_ff @(posedge i_core_clk) begin
    if (!i_reset_n || soft_rst) begin
      pd_r <= 1'b0;
    end else if (!ctrl_r[RPD_PD_EN_BIT] || i_ev.wake_tone || i_ev.act_req) begin
      pd_r <= 1'b0; // [R09] [R10]
    end else if (i_ev.waiting_tone) begin
      pd_r <= 1'b1; // [R08]
    end
  end

  // Coefficient clear pulses on entry to absolute power-down.
  always_ff @(posedge i_core_clk) begin
    if (!i_reset_n) begin
      abs_q_r <= 1'b0;
      o_coef_clear <= 1'b0;
    end else begin
      abs_q_r <= ctrl_r[RPD_ABS_PD_BIT];
      o_coef_clear <= ctrl_r[RPD_ABS_PD_BIT] && !abs_q_r; // [R13]
    end
  end

  // Counts cycles of lost or badly errored framing while linked.
  always_ff @(posedge i_core_clk) begin
    if (!i_reset_n || soft_rst || i_ev.frame_ok) begin
      loss_cnt_r <= 32'h0000_0000;
    end else if (stat_r[RPD_LINKUP_BIT] && !loss_expired) begin
      loss_cnt_r <= loss_cnt_r + 32'h0000_0001;
    end
  end
  assign loss_expired = loss_cnt_r >= LOSS_CYCLES[31:0] - 32'h0000_0001;

  // Next status from the activation events.
  always_comb begin
    stat_nxt = stat_r;
    if (i_ev.full_duplex) begin
      stat_nxt[RPD_LINKUP_BIT] = 1'b1; // [R18]
    end
    if (loss_expired || i_ev.nt_deact || i_ev.lt_deact_req) begin
      stat_nxt[RPD_LINKUP_BIT] = 1'b0; // [R19]
    end
    stat_nxt[RPD_SFSYNC_BIT] = i_ev.sf_sync && stat_nxt[RPD_LINKUP_BIT];
    if (i_ev.act_start) begin
      stat_nxt[RPD_TRANSP_BIT] = 1'b1;
    end
    if (i_ev.act_fail || i_ev.high_error) begin
      stat_nxt[RPD_TRANSP_BIT] = 1'b0;
    end
    if (i_ev.act_req || i_ev.wake_tone) begin
      stat_nxt[RPD_ERR_BIT] = 1'b0; // [R21]
    end
    if (i_ev.timer_expired || loss_expired || i_ev.act_fail) begin
      stat_nxt[RPD_ERR_BIT] = 1'b1; // [R20]
    end
  end
  assign rise = stat_nxt & ~stat_r;
  assign fall = stat_r & ~stat_nxt & 4'b1011;

  // Status register ignores bus writes and clears on either reset.
  always_ff @(posedge i_core_clk) begin
    if (!i_reset_n || soft_rst) begin
      stat_r <= RPD_STAT_RESET; // [R15]
    end else begin
      stat_r <= stat_nxt; // [R02] [R22]
    end
  end

  // Status-change interrupt; a new change wins over the clearing read.
  always_ff @(posedge i_core_clk) begin
    if (!i_reset_n || soft_rst) begin
      irq_r <= 1'b0;
    end else if ((|rise) || (|fall)) begin
      irq_r <= 1'b1; // [R16]
    end else if (rd_acc && i_paddr == RPD_STAT_ADDR) begin
      irq_r <= 1'b0; // [R16]
    end
  end

  // D-channel code flag; cleared by reading the D-channel register.
  always_ff @(posedge i_core_clk) begin
    if (!i_reset_n || soft_rst || !i_dch_enable) begin
      dch_r <= 1'b0;
    end else if (i_ev.d_chan_avail) begin
      dch_r <= 1'b1; // [R17]
    end else if (rd_acc && i_paddr == RPD_DCH_ADDR) begin
      dch_r <= 1'b0; // [R17]
    end
  end

  // Read mux; control reads zero during absolute power-down as it is write-only then.
  always_comb begin
    rdata_nxt = 32'h0000_0000;
    if (i_paddr == RPD_CTRL_ADDR) begin
      if (!ctrl_r[RPD_ABS_PD_BIT]) begin
        rdata_nxt[3:0] = ctrl_r; // [R01] [R05]
      end
    end else if (ctrl_r[RPD_ABS_PD_BIT]) begin
      rdata_nxt = 32'h0000_0000;
    end else if (i_paddr == RPD_STAT_ADDR) begin
      rdata_nxt[3:0] = dch_r ? RPD_DCH_CODE : stat_r; // [R17]
    end else if (i_paddr == RPD_DIAG_ADDR) begin
      rdata_nxt[7:0] = diag_r;
    end else if (i_paddr == RPD_DCH_ADDR) begin
      rdata_nxt[0] = dch_r;
    end else if (i_paddr == RPD_CORE_ADDR) begin
      // Write-only style core state is visible only in diagnostic mode.
      if (diag_r[RPD_DIAG_RW_BIT]) begin
        rdata_nxt[2:0] = {o_coef_clear, pd_r, o_rtn_pulse}; // [R03]
      end
    end
  end
  assign o_prdata = rdata_nxt;

  // Core-facing controls are registered so they are clean from reset.
  always_ff @(posedge i_core_clk) begin
    if (!i_reset_n) begin
      o_core_reset <= 1'b0;
      o_power_down <= 1'b0;
      o_abs_power_down <= 1'b0;
      o_tx_hiz <= 1'b0;
      o_status_irq <= 1'b0;
    end else begin
      o_core_reset <= soft_rst; // [R06] [R11]
      o_power_down <= pd_r; // [R08]
      o_abs_power_down <= ctrl_r[RPD_ABS_PD_BIT]; // [R11]
      o_tx_hiz <= ctrl_r[RPD_ABS_PD_BIT] || pd_r; // [R11]
      o_status_irq <= irq_r;
    end
  end

  a_swrst_holds: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
    ctrl_r[RPD_SW_RESET_BIT] |=> o_core_reset) else $error("core reset not held"); // [R06]
  a_stat_clears: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
    soft_rst |=> stat_r == 4'h0) else $error("status not cleared"); // [R15]
  a_irq_on_rise: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
    (!soft_rst && (|rise)) |=> irq_r ##1 o_status_irq) else $error("irq missed"); // [R16]
  a_pd_exit: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
    !ctrl_r[RPD_PD_EN_BIT] |=> !pd_r) else $error("power-down while disabled"); // [R10]
  a_ctrl_readback: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
    (wr_acc && i_paddr == RPD_CTRL_ADDR) |=> ctrl_r == $past(i_pwdata[3:0]))
    else $error("control write lost"); // [R01]
  a_dch_code: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
    (dch_r && i_paddr == RPD_STAT_ADDR && !ctrl_r[RPD_ABS_PD_BIT]) |-> o_prdata[3:0] == 4'hf)
    else $error("d-channel code missing"); // [R17]
  a_err_sticky: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
    (stat_r[RPD_ERR_BIT] && !soft_rst && !i_ev.act_req && !i_ev.wake_tone) |=> stat_r[RPD_ERR_BIT])
    else $error("error bit dropped"); // [R21]
  a_coef_clear: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
    $rose(ctrl_r[RPD_ABS_PD_BIT]) |=> o_coef_clear) else $error("coefficients kept"); // [R13]

  // A status change reaches the pin in two steps: the flag, then the registered pin.
  sequence s_irq_flag_then_pin;
    irq_r ##1 o_status_irq;
  endsequence

  // Falling link, sync or transparent bits must raise the interrupt as rises do.
  a_irq_on_fall: assert property (@(posedge i_core_clk) disable iff (!i_reset_n) // [R16]
    (!soft_rst && (|fall)) |=> s_irq_flag_then_pin)
    else $error("irq missed on fall");
  // A status read with no new change in the same cycle clears the flag.
  a_irq_rd_clear: assert property (@(posedge i_core_clk) disable iff (!i_reset_n) // [R16]
    (rd_acc && i_paddr == RPD_STAT_ADDR && !(|rise) && !(|fall)) |=> !irq_r)
    else $error("irq not cleared by read");
  // Only a status read or a reset may drop a pending change; the D-channel read may not.
  a_irq_kept: assert property (@(posedge i_core_clk) disable iff (!i_reset_n) // [R17]
    (irq_r && !soft_rst && !(rd_acc && i_paddr == RPD_STAT_ADDR)) |=> irq_r)
    else $error("pending irq lost");
  // Reading the D-channel register removes the all-ones code.
  a_dch_rd_clear: assert property (@(posedge i_core_clk) disable iff (!i_reset_n) // [R17]
    (rd_acc && i_paddr == RPD_DCH_ADDR && !i_ev.d_chan_avail) |=> !dch_r)
    else $error("d-channel code not cleared");

  // Hardware reset leaves the control register at its cleared value.
  a_ctrl_hw_reset: assert property (@(posedge i_core_clk) // [R04]
    !i_reset_n |=> ctrl_r == RPD_CTRL_RESET)
    else $error("control not cleared by reset");
  // Nothing but a bus write may move the control bits; software reset keeps them.
  a_ctrl_stable: assert property (@(posedge i_core_clk) disable iff (!i_reset_n) // [R04]
    !(wr_acc && i_paddr == RPD_CTRL_ADDR) |=> $stable(ctrl_r))
    else $error("control changed without write");
  // The core leaves reset once both reset sources are gone.
  a_core_release: assert property (@(posedge i_core_clk) disable iff (!i_reset_n) // [R06]
    (!ctrl_r[RPD_SW_RESET_BIT] && !ctrl_r[RPD_ABS_PD_BIT]) |=> !o_core_reset)
    else $error("core reset stuck");

  // Absolute power-down turns the bus into a write-only control port.
  a_abs_rd_zero: assert property (@(posedge i_core_clk) disable iff (!i_reset_n) // [R05]
    (ctrl_r[RPD_ABS_PD_BIT] && i_psel && i_penable) |-> o_prdata == 32'h0000_0000)
    else $error("read data during absolute power-down");
  // Writes to other registers have no effect while powered down.
  a_abs_wr_block: assert property (@(posedge i_core_clk) disable iff (!i_reset_n) // [R05]
    (ctrl_r[RPD_ABS_PD_BIT] && wr_acc && i_paddr == RPD_DIAG_ADDR) |=> diag_r == 8'h00)
    else $error("write accepted in absolute power-down");
  // Absolute power-down resets the core and floats the drivers.
  a_abs_outputs: assert property (@(posedge i_core_clk) disable iff (!i_reset_n) // [R11]
    ctrl_r[RPD_ABS_PD_BIT] |=> o_tx_hiz && o_core_reset && o_abs_power_down)
    else $error("absolute power-down outputs wrong");
  // The ordinary power-down state is part of what absolute power-down resets.
  a_abs_no_pd: assert property (@(posedge i_core_clk) disable iff (!i_reset_n) // [R11]
    ctrl_r[RPD_ABS_PD_BIT] |=> !pd_r)
    else $error("power-down state survived reset");

  // Enabled and waiting for a tone with nothing to wake it means power-down.
  a_pd_entry: assert property (@(posedge i_core_clk) disable iff (!i_reset_n) // [R08]
    (!soft_rst && ctrl_r[RPD_PD_EN_BIT] && i_ev.waiting_tone && !i_ev.wake_tone
     && !i_ev.act_req) |=> pd_r)
    else $error("power-down not entered");
  // A tone or an activation request always wakes the transceiver.
  a_pd_wake: assert property (@(posedge i_core_clk) disable iff (!i_reset_n) // [R09]
    (i_ev.wake_tone || i_ev.act_req) |=> !pd_r)
    else $error("power-down not left");
  // The power-down pin follows the internal state one cycle later.
  a_pd_pin: assert property (@(posedge i_core_clk) disable iff (!i_reset_n) // [R08]
    1'b1 |=> o_power_down == $past(pd_r))
    else $error("power-down pin wrong");

  // Return-to-normal yields exactly one pulse per write of one.
  a_rtn_pulse: assert property (@(posedge i_core_clk) disable iff (!i_reset_n) // [R14]
    (wr_acc && i_paddr == RPD_CTRL_ADDR && i_pwdata[RPD_RTN_BIT]) |=> o_rtn_pulse)
    else $error("return-to-normal pulse missing");
  // No pulse appears without a control write behind it.
  a_rtn_quiet: assert property (@(posedge i_core_clk) disable iff (!i_reset_n) // [R14]
    !(wr_acc && i_paddr == RPD_CTRL_ADDR) |=> !o_rtn_pulse)
    else $error("spurious return-to-normal pulse");

  // A status write must leave the bits to the activation logic alone.
  a_stat_no_write: assert property (@(posedge i_core_clk) disable iff (!i_reset_n) // [R22]
    (wr_acc && i_paddr == RPD_STAT_ADDR && !soft_rst) |=> stat_r == $past(stat_nxt))
    else $error("status took a bus write");
  // Full duplex without a competing drop sets link-up.
  a_linkup_set: assert property (@(posedge i_core_clk) disable iff (!i_reset_n) // [R18]
    (!soft_rst && i_ev.full_duplex && !loss_expired && !i_ev.nt_deact
     && !i_ev.lt_deact_req) |=> stat_r[RPD_LINKUP_BIT])
    else $error("link-up not set");
  // Superframe sync is never shown without link-up.
  a_sync_link: assert property (@(posedge i_core_clk) disable iff (!i_reset_n) // [R18]
    stat_r[RPD_SFSYNC_BIT] |-> stat_r[RPD_LINKUP_BIT])
    else $error("sync without link-up");
  // Deactivation in either mode drops link-up.
  a_linkup_deact: assert property (@(posedge i_core_clk) disable iff (!i_reset_n) // [R19]
    (!soft_rst && (i_ev.nt_deact || i_ev.lt_deact_req)) |=> !stat_r[RPD_LINKUP_BIT])
    else $error("link-up kept after deactivation");
  // Long loss of framing drops link-up.
  a_linkup_loss: assert property (@(posedge i_core_clk) disable iff (!i_reset_n) // [R19]
    (!soft_rst && loss_expired) |=> !stat_r[RPD_LINKUP_BIT])
    else $error("link-up kept after framing loss");
  // Any timer expiry shows up as an error indication.
  a_err_set: assert property (@(posedge i_core_clk) disable iff (!i_reset_n) // [R20]
    (!soft_rst && i_ev.timer_expired) |=> stat_r[RPD_ERR_BIT])
    else $error("error indication not set");
  // A restart clears the error unless an expiry or an activation failure lands in the same cycle.
  a_err_autoclr: assert property (@(posedge i_core_clk) disable iff (!i_reset_n) // [R21]
    (!soft_rst && (i_ev.act_req || i_ev.wake_tone) && !i_ev.timer_expired
     && !loss_expired && !i_ev.act_fail) |=> !stat_r[RPD_ERR_BIT])
    else $error("error indication not cleared");

  // Core bits stay hidden unless the diagnostic bit opens them.
  a_diag_hidden: assert property (@(posedge i_core_clk) disable iff (!i_reset_n) // [R03]
    (!diag_r[RPD_DIAG_RW_BIT] && i_paddr == RPD_CORE_ADDR) |-> o_prdata == 32'h0000_0000)
    else $error("core bits visible");
  // With the diagnostic bit set the core bits read back as driven.
  a_diag_shown: assert property (@(posedge i_core_clk) disable iff (!i_reset_n) // [R03]
    (diag_r[RPD_DIAG_RW_BIT] && i_paddr == RPD_CORE_ADDR && !ctrl_r[RPD_ABS_PD_BIT])
    |-> o_prdata[2:0] == {o_coef_clear, pd_r, o_rtn_pulse})
    else $error("core bits not readable");
endmodule // rpd_bank

// ---- rtl/rpd_pkg.sv ----
// Package with register map, field positions and timing counts for the reset/status bank.
// What this block does
// [R01] Read/write bits read back last written value
// [R02] Read-only bits ignore writes, internal logic sets
// [R03] Diagnostic bit b6 makes write-only bits readable
// [R04] Control register cleared by hardware reset only
// [R05] Absolute power-down: control register write-only, sole writable
// [R06] Software reset holds core reset until cleared
// [R07] Controller holds reset six slow clock periods
// [R08] Power-down enable while awaiting tone enters power-down
// [R09] Tone, activation request or enable clear exit power-down
// [R10] Enable low never powers down; warm start kept
// [R11] Absolute power-down resets, stops clocks, tristates drivers
// [R12] Controller pulses software reset 1 ms after exit
// [R13] Absolute power-down clears coefficients; hardware reset ends it
// [R14] Return-to-normal clears checksum-corrupt and loopback bits
// [R15] Status register cleared by any reset
// [R16] Status changes raise interrupt, except the error bit clearing; status read clears it
// [R17] D-channel code 1111 shown; its read keeps pending
// [R18] Link-up set when full duplex established
// [R19] Link-up held until loss, deactivation or reset
// [R20] Error indication set on any timer expiry
// [R21] Error indication survives read; cleared by restart
// [R22] Status register ignores software writes
package rpd_pkg;
  localparam logic [11:0] RPD_CTRL_ADDR = 12'h000;
  localparam logic [11:0] RPD_STAT_ADDR = 12'h004;
  localparam logic [11:0] RPD_DIAG_ADDR = 12'h008;
  localparam logic [11:0] RPD_DCH_ADDR = 12'h00c;
  localparam logic [11:0] RPD_CORE_ADDR = 12'h010;
  localparam int RPD_SW_RESET_BIT = 3;
  localparam int RPD_PD_EN_BIT = 2;
  localparam int RPD_ABS_PD_BIT = 1;
  localparam int RPD_RTN_BIT = 0;
  localparam int RPD_LINKUP_BIT = 3;
  localparam int RPD_ERR_BIT = 2;
  localparam int RPD_SFSYNC_BIT = 1;
  localparam int RPD_TRANSP_BIT = 0;
  localparam int RPD_DIAG_RW_BIT = 6;
  localparam logic [3:0] RPD_CTRL_RESET = 4'h0;
  localparam logic [3:0] RPD_STAT_RESET = 4'h0;
  localparam logic [3:0] RPD_DCH_CODE = 4'hf;
  localparam int RPD_CORE_CLK_MHZ = 200;
  localparam int RPD_LINK_LOSS_MS = 480;
  // Milliseconds to microseconds, then microseconds times MHz gives core cycles.
  localparam int RPD_LINK_LOSS_CYC = RPD_LINK_LOSS_MS * 1000 * RPD_CORE_CLK_MHZ;
  // Internal status events from the activation logic.
  typedef struct packed {
    logic full_duplex;
    logic frame_ok;
    logic sf_sync;
    logic act_start;
    logic act_fail;
    logic high_error;
    logic timer_expired;
    logic wake_tone;
    logic nt_deact;
    logic lt_deact_req;
    logic waiting_tone;
    logic act_req;
    logic d_chan_avail;
  } rpd_act_ev_t;
endpackage : rpd_pkg

// ---- dv/rpd_apb_host.sv ----
// APB master model standing in for the microcontroller that programs the bank.
module rpd_apb_host (
  input wire logic i_clk,
  input wire logic i_pready,
  input wire logic i_pslverr,
  input wire logic [31:0] i_prdata,
  output logic o_psel,
  output logic o_penable,
  output logic o_pwrite,
  output logic [11:0] o_paddr,
  output logic [31:0] o_pwdata
);
  timeunit 1ns;
  timeprecision 1ps;
  import rpd_pkg::*;
  // Idle bus from time zero.
  initial begin
    o_psel = 1'b0;
    o_penable = 1'b0;
    o_pwrite = 1'b0;
    o_paddr = 12'h000;
    o_pwdata = 32'h0;
  end
  // One transfer; the request is held until pready is seen high at an edge.
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic e);
    @(posedge i_clk);
    o_psel <= 1'b1;
    o_pwrite <= w;
    o_paddr <= a;
    o_pwdata <= d;
    @(posedge i_clk);
    o_penable <= 1'b1;
    @(posedge i_clk);
    while (i_pready !== 1'b1) @(posedge i_clk);
    q = i_prdata;
    e = i_pslverr;
    o_psel <= 1'b0;
    o_penable <= 1'b0;
  endtask
  // Clocks need a software-reset pulse to settle; settle is shortened in sim.
  task automatic abs_exit(input int settle);
    logic [31:0] q;
    logic e;
    xfer(1'b1, RPD_CTRL_ADDR, 32'h0, q, e);
    xfer(1'b1, RPD_CTRL_ADDR, 32'h8, q, e);
    repeat (settle) @(posedge i_clk);
    xfer(1'b1, RPD_CTRL_ADDR, 32'h0, q, e);
  endtask
endmodule // rpd_apb_host

// ---- dv/reset_powerdown_activation_status_tb.sv ----
// Self-checking bench for the reset, power-down and status register bank.
module reset_powerdown_activation_status_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import rpd_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic psel, pen, pwr, rdy, serr, dch = 1'b0;
  logic [11:0] addr;
  logic [31:0] wdata, rdata, q;
  logic e, core_rst, pd, apd, hiz, coef, rtn, irq, coef_seen = 1'b0, rtn_seen = 1'b0;
  rpd_act_ev_t ev = '0;
  int fail_count = 0;
  int cmp_count = 0;
  // 200 MHz core clock.
  always #2.5 clk = ~clk;
  rpd_bank #(.LOSS_CYCLES(20)) u_dut (.i_core_clk(clk), .i_reset_n(rst_n), .i_psel(psel),
    .i_penable(pen), .i_pwrite(pwr), .i_paddr(addr), .i_pwdata(wdata), .o_prdata(rdata),
    .o_pready(rdy), .o_pslverr(serr), .i_ev(ev), .i_dch_enable(dch), .o_core_reset(core_rst),
    .o_power_down(pd), .o_abs_power_down(apd), .o_tx_hiz(hiz), .o_coef_clear(coef),
    .o_rtn_pulse(rtn), .o_status_irq(irq));
  rpd_apb_host u_host (.i_clk(clk), .i_pready(rdy), .i_pslverr(serr), .i_prdata(rdata),
    .o_psel(psel), .o_penable(pen), .o_pwrite(pwr), .o_paddr(addr), .o_pwdata(wdata));
  // One-cycle pulses are latched so a later look cannot miss them.
  always @(posedge clk) begin
    if (coef === 1'b1) coef_seen <= 1'b1;
    if (rtn === 1'b1) rtn_seen <= 1'b1;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED at %0t: %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [3:0] v);
    u_host.xfer(1'b1, a, {28'h0, v}, q, e);
  endtask
  task automatic rd(input logic [11:0] a);
    u_host.xfer(1'b0, a, 32'h0, q, e);
  endtask
  // Let registered outputs land before they are looked at.
  task automatic settle();
    repeat (3) @(posedge clk);
    #1;
  endtask
  task automatic pulse(input rpd_act_ev_t m);
    @(posedge clk);
    ev <= rpd_act_ev_t'(ev | m);
    @(posedge clk);
    ev <= rpd_act_ev_t'(ev & ~m);
  endtask
  task automatic t_regs();
    rd(RPD_CTRL_ADDR);
    chk(q, 32'h0, "ctrl reset");
    rd(RPD_STAT_ADDR);
    chk(q, 32'h0, "stat reset");
    rd(12'h020);
    chk({31'h0, e}, 32'h1, "unmapped err");
    wr(RPD_STAT_ADDR, 4'hf);
    rd(RPD_STAT_ADDR);
    chk(q, 32'h0, "stat write ignored");
    wr(RPD_CTRL_ADDR, 4'h8);
    settle();
    chk({31'h0, core_rst}, 32'h1, "soft reset held");
    rd(RPD_CTRL_ADDR);
    chk(q, 32'h8, "ctrl kept");
    wr(RPD_CTRL_ADDR, 4'h1);
    settle();
    chk({30'h0, core_rst, rtn_seen}, 32'h1, "rtn pulse");
    $display("test regs done");
  endtask
  task automatic t_pd();
    @(posedge clk);
    ev.waiting_tone <= 1'b1;
    wr(RPD_CTRL_ADDR, 4'h0);
    settle();
    chk({31'h0, pd}, 32'h0, "no pd when disabled");
    wr(RPD_CTRL_ADDR, 4'h4);
    settle();
    chk({31'h0, pd}, 32'h1, "pd entered");
    @(posedge clk);
    ev.waiting_tone <= 1'b0;
    pulse('{wake_tone: 1'b1, default: 1'b0});
    settle();
    chk({31'h0, pd}, 32'h0, "tone wakes");
    wr(RPD_CTRL_ADDR, 4'h2);
    settle();
    chk({29'h0, apd, hiz, core_rst}, 32'h7, "abs pd");
    chk({31'h0, coef_seen}, 32'h1, "coef clear");
    rd(RPD_CTRL_ADDR);
    chk(q, 32'h0, "ctrl write-only");
    u_host.abs_exit(20);
    settle();
    chk({30'h0, apd, core_rst}, 32'h0, "abs pd left");
    $display("test power-down done");
  endtask
  task automatic t_stat();
    @(posedge clk);
    ev.frame_ok <= 1'b1;
    ev.full_duplex <= 1'b1;
    settle();
    chk({31'h0, irq}, 32'h1, "irq on rise");
    rd(RPD_STAT_ADDR);
    chk(q, 32'h8, "linkup");
    settle();
    chk({31'h0, irq}, 32'h0, "irq read clear");
    pulse('{timer_expired: 1'b1, default: 1'b0});
    settle();
    rd(RPD_STAT_ADDR);
    rd(RPD_STAT_ADDR);
    chk(q, 32'hc, "err kept on read");
    @(posedge clk);
    ev.frame_ok <= 1'b0;
    ev.full_duplex <= 1'b0;
    repeat (30) @(posedge clk);
    rd(RPD_STAT_ADDR);
    chk(q, 32'h4, "linkup lost");
    wr(RPD_CTRL_ADDR, 4'h8);
    wr(RPD_CTRL_ADDR, 4'h0);
    rd(RPD_STAT_ADDR);
    chk(q, 32'h0, "soft reset clears");
    @(posedge clk);
    dch <= 1'b1;
    pulse('{d_chan_avail: 1'b1, default: 1'b0});
    settle();
    rd(RPD_STAT_ADDR);
    chk(q, 32'hf, "dch code");
    rd(RPD_DCH_ADDR);
    rd(RPD_STAT_ADDR);
    chk(q, 32'h0, "dch code gone");
    $display("test status done");
  endtask
  task automatic stop_test();
    $display("compares %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // Main sequence after a four-cycle reset held with the clock running.
  initial begin
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    t_regs();
    t_pd();
    t_stat();
    stop_test();
  end
  // Watchdog; the tests need well under 2000 cycles.
  initial begin
    #20us;
    fail_count++;
    stop_test();
  end
endmodule // reset_powerdown_activation_status_tb
